// file: rtl/php_pin_sync.sv
`timescale 1ns/1ns

// shared constants and types for the palette host port
package php_pkg;

  // widths of the host port and the colour store
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PTR_W = 8;
  localparam int unsigned WORD_W = 24;
  localparam int unsigned DEPTH = 256;

  // overlay slot selection uses the two lowest pointer bits
  localparam int unsigned OVL_SEL_W = 2;
  localparam logic [1:0] OVL_RESERVED = 2'h0;
  localparam logic [1:0] OVL_FIRST = 2'h1;
  localparam logic [1:0] OVL_LAST = 2'h3;

  // constant values used by the logic
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] PTR_ZERO = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [23:0] WORD_ZERO = 24'h000000;

  // width of the bundle of host pins that cross into core_clk
  localparam int unsigned PIN_W = 13;

  // hidden colour phase, counts red, green, blue then wraps
  typedef enum logic [1:0] {
    PH_RED,
    PH_GREEN,
    PH_BLUE
  } php_phase_t;

  // host pins as one bundle, idle means no strobe asserted
  typedef struct packed {
    logic sel_n;
    logic rd_n;
    logic wr_n;
    logic cmd_hi;
    logic cmd_lo;
    logic [7:0] data;
  } php_pins_t;

  // one colour word, red in the top byte
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } php_color_t;

  // value the pin bundle takes in reset: all strobes high
  localparam php_pins_t PINS_IDLE = '{
    sel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
    cmd_hi: 1'b0, cmd_lo: 1'b0, data: 8'h00};

endpackage

// three-stage pin synchroniser with agreement filter
module php_pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  // first stage, read only by the second
  logic [WIDTH-1:0] meta_r;
  // second and third stages
  logic [WIDTH-1:0] sync2_r;
  logic [WIDTH-1:0] sync3_r;
  // filtered value, moves only when stages two and three agree
  logic [WIDTH-1:0] stable_r;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] stable_nxt;

  // per bit: take the new level once two samples match
  assign agree = ~(sync2_r ^ sync3_r);
  assign stable_nxt = (agree & sync3_r) | (~agree & stable_r);

  // shift chain
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      meta_r <= IDLE;
      sync2_r <= IDLE;
      sync3_r <= IDLE;
      stable_r <= IDLE;
    end
    else
    begin
      meta_r <= pin_in;
      sync2_r <= meta_r;
      sync3_r <= sync2_r;
      stable_r <= stable_nxt;
    end
  end

  assign pin_out = stable_r;

endmodule

// file: rtl/php_palette_port.sv
`timescale 1ns/1ns

// Overview of operation
// (RL1) host reaches colour storage only while selected
// (RL2) pixel and overlay inputs ignored while selected
// (RL3) command bits pick pointer, palette or overlays
// (RL4) eight-bit pointer indexes palette and overlays
// (RL5) pointer write loads data bus into pointer
// (RL6) three byte writes, blue stores whole word
// (RL7) pointer steps after each blue write
// (RL8) three byte reads, pointer steps after blue
// (RL9) palette pointer wraps from last to zero
// (RL10) video outputs black while host is selected
// (RL11) overlays use two low bits, zero reserved
// (RL12) pixel lookups run between host accesses
// (RL13) host should load colours during blanking
// (RL14) hidden phase counts red, green, blue modulo three
// (RL15) pointer write clears phase, pointer read keeps it
// (RL16) pointer read disturbs neither pointer nor mode
// (RL17) pointer bit zero is index least significant
// (RL18) write data taken when either strobe rises
// (RL19) host never asserts select, read, write together
// (RL20) eight-bit bus, driven while select and read low
// (RL21) reserved overlay stores nothing, reads zero
// (RL22) bus released outside select-and-read window
module php_palette_port #(
  parameter int unsigned DEPTH = php_pkg::DEPTH
) (
  input wire logic core_clk,
  input wire logic srst,
  // host strobes, active low
  input wire logic host_sel_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  // command inputs
  input wire logic cmd_sel_lo,
  input wire logic cmd_sel_hi,
  // two-way data bus as three signals
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe,
  // pixel side lookup inputs, same clock domain
  input wire logic [7:0] pixel_index,
  input wire logic overlay_sel_bit0,
  input wire logic overlay_sel_bit1,
  // digital codes for the three colour converters
  output logic [7:0] red_current_out,
  output logic [7:0] green_current_out,
  output logic [7:0] blue_current_out
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------

  // colour lookup memory, one 24-bit word per location
  php_pkg::php_color_t palette_mem [0:DEPTH-1];
  // overlay colours one to three, slot zero does not exist
  php_pkg::php_color_t overlay_r [php_pkg::OVL_FIRST:php_pkg::OVL_LAST];

  // pointer visible to the host
  logic [7:0] palette_pointer_r;
  logic [7:0] palette_pointer_nxt;
  // hidden colour phase
  php_pkg::php_phase_t phase_r;
  php_pkg::php_phase_t phase_nxt;
  // red and green bytes held until blue arrives
  logic [7:0] red_hold_r;
  logic [7:0] green_hold_r;

  // ---------------------------------------------------------------
  // host pins into core_clk
  // ---------------------------------------------------------------

  // raw pin bundle
  php_pkg::php_pins_t pins_raw;
  // filtered pin bundle
  php_pkg::php_pins_t pins;

  assign pins_raw.sel_n = host_sel_n;
  assign pins_raw.rd_n = host_rd_n;
  assign pins_raw.wr_n = host_wr_n;
  assign pins_raw.cmd_hi = cmd_sel_hi;
  assign pins_raw.cmd_lo = cmd_sel_lo;
  assign pins_raw.data = host_data_bus_in;

  // the port has no relation to core_clk, so every pin is filtered
  php_pin_sync #(
    .WIDTH(php_pkg::PIN_W),
    .IDLE(php_pkg::PINS_IDLE)
  ) u_pin_sync (
    .core_clk(core_clk),
    .srst(srst),
    .pin_in(pins_raw),
    .pin_out(pins)
  );

  // ---------------------------------------------------------------
  // host cycle decode
  // ---------------------------------------------------------------

  // select asserted
  wire host_selected = ~pins.sel_n; // RL1
  // write window: select and write low, read high
  wire wr_active = host_selected & ~pins.wr_n & pins.rd_n;
  // read window: select and read low, write high
  wire rd_active = host_selected & ~pins.rd_n & pins.wr_n; // RL20
  // previous window levels for edge detection
  logic wr_active_r;
  logic rd_active_r;
  // write ends when either strobe rises
  wire wr_end = wr_active_r & ~wr_active; // RL18
  // read ends when either strobe rises
  wire rd_end = rd_active_r & ~rd_active;
  // read starts
  wire rd_start = rd_active & ~rd_active_r;

  // command and data sampled during the cycle, used at its end
  logic cmd_lo_r;
  logic cmd_hi_r;
  logic [7:0] wr_data_r;

  // target of the cycle as seen at its end
  wire end_is_pointer = ~cmd_lo_r; // RL3
  wire end_is_overlay = cmd_lo_r & cmd_hi_r; // RL3
  // live command decode for read data
  wire live_is_pointer = ~pins.cmd_lo; // RL3
  wire live_is_overlay = pins.cmd_lo & pins.cmd_hi; // RL3

  // ---------------------------------------------------------------
  // location addressed by the pointer
  // ---------------------------------------------------------------

  // overlay slot from the low bits, upper six ignored
  wire [1:0] ovl_slot =
    palette_pointer_r[php_pkg::OVL_SEL_W-1:0]; // RL11 RL17
  // reserved slot
  wire ovl_reserved = (ovl_slot == php_pkg::OVL_RESERVED); // RL21

  // colour word at the pointer, palette side
  php_pkg::php_color_t ram_word;
  assign ram_word = palette_mem[palette_pointer_r]; // RL4 RL17
  // colour word at the pointer, overlay side
  php_pkg::php_color_t ovl_word;
  assign ovl_word = ovl_reserved ? php_pkg::WORD_ZERO
                                 : overlay_r[ovl_slot]; // RL21
  // chosen by the high command bit
  php_pkg::php_color_t host_word;
  assign host_word = live_is_overlay ? ovl_word : ram_word;

  // byte of that word for the current phase
  logic [7:0] phase_byte;
  assign phase_byte = (phase_r == php_pkg::PH_RED)   ? host_word.red :
                      (phase_r == php_pkg::PH_GREEN) ? host_word.green :
                                                       host_word.blue;

  // value placed on the bus for this read
  wire [7:0] rd_value = live_is_pointer ? palette_pointer_r
                                        : phase_byte; // RL16

  // word assembled on the blue write
  php_pkg::php_color_t wr_word;
  assign wr_word = '{red: red_hold_r, green: green_hold_r,
                     blue: wr_data_r}; // RL6

  // ---------------------------------------------------------------
  // pointer and phase next state
  // ---------------------------------------------------------------

  // colour byte cycle ended (read or write, not the pointer)
  wire color_end = (wr_end | rd_end) & cmd_lo_r; // RL14
  // blue byte cycle ended
  wire blue_end = color_end & (phase_r == php_pkg::PH_BLUE);
  // pointer load
  wire ptr_load = wr_end & end_is_pointer; // RL5

  // pointer: load, step after blue, else hold
  always_comb
  begin
    palette_pointer_nxt = palette_pointer_r;
    if (ptr_load)
    begin
      // host sets the location
      palette_pointer_nxt = wr_data_r; // RL5
    end
    else if (blue_end)
    begin
      // natural 8-bit overflow gives the wrap to zero
      palette_pointer_nxt = palette_pointer_r + php_pkg::PTR_STEP; // RL7 RL8 RL9
    end
  end

  // phase: cleared by pointer write, kept by pointer read
  always_comb
  begin
    phase_nxt = phase_r;
    if (ptr_load)
    begin
      phase_nxt = php_pkg::PH_RED; // RL15
    end
    else if (color_end)
    begin
      case (phase_r)
        php_pkg::PH_RED: phase_nxt = php_pkg::PH_GREEN; // RL14
        php_pkg::PH_GREEN: phase_nxt = php_pkg::PH_BLUE; // RL14
        default: phase_nxt = php_pkg::PH_RED; // RL14
      endcase
    end
  end

  // ---------------------------------------------------------------
  // host side registers
  // ---------------------------------------------------------------

  // window levels and sampled command/data
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wr_active_r <= 1'b0;
      rd_active_r <= 1'b0;
      cmd_lo_r <= 1'b0;
      cmd_hi_r <= 1'b0;
      wr_data_r <= php_pkg::BYTE_ZERO;
    end
    else
    begin
      wr_active_r <= wr_active;
      rd_active_r <= rd_active;
      // track the bus while a window is open; last value wins
      if (wr_active | rd_active)
      begin
        cmd_lo_r <= pins.cmd_lo;
        cmd_hi_r <= pins.cmd_hi;
        wr_data_r <= pins.data; // RL18
      end
    end
  end

  // pointer and phase
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      palette_pointer_r <= php_pkg::PTR_ZERO;
      phase_r <= php_pkg::PH_RED;
    end
    else
    begin
      palette_pointer_r <= palette_pointer_nxt;
      phase_r <= phase_nxt;
    end
  end

  // red and green staging bytes
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      red_hold_r <= php_pkg::BYTE_ZERO;
      green_hold_r <= php_pkg::BYTE_ZERO;
    end
    else if (wr_end & cmd_lo_r)
    begin
      if (phase_r == php_pkg::PH_RED)
      begin
        red_hold_r <= wr_data_r; // RL6
      end
      else if (phase_r == php_pkg::PH_GREEN)
      begin
        green_hold_r <= wr_data_r; // RL6
      end
    end
  end

  // blue write commits to palette memory, no reset on the array
  always_ff @(posedge core_clk)
  begin
    if (wr_end & blue_end & ~end_is_overlay)
    begin
      palette_mem[palette_pointer_r] <= wr_word; // RL6
    end
  end

  // blue write commits to an overlay, reserved slot dropped
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      for (int i = php_pkg::OVL_FIRST; i <= php_pkg::OVL_LAST; i++)
      begin
        overlay_r[i] <= php_pkg::WORD_ZERO;
      end
    end
    else if (wr_end & blue_end & end_is_overlay & ~ovl_reserved)
    begin
      overlay_r[ovl_slot] <= wr_word; // RL11 RL21
    end
  end

  // ---------------------------------------------------------------
  // data bus drive
  // ---------------------------------------------------------------

  // read byte latched at the window start, released at its end
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      host_data_bus_out <= php_pkg::BYTE_ZERO;
      host_data_bus_oe <= 1'b0;
    end
    else
    begin
      // drive only inside select-and-read
      host_data_bus_oe <= rd_active; // RL22
      if (rd_start)
      begin
        host_data_bus_out <= rd_value; // RL8 RL16
      end
    end
  end

  // ---------------------------------------------------------------
  // pixel side lookup
  // ---------------------------------------------------------------

  // overlay selection from the frame buffer
  wire [1:0] pix_ovl = {overlay_sel_bit1, overlay_sel_bit0};
  // word from memory or overlays
  php_pkg::php_color_t pix_word;
  assign pix_word = (pix_ovl == php_pkg::OVL_RESERVED)
                    ? palette_mem[pixel_index]
                    : overlay_r[pix_ovl];

  // colour outputs: black while selected, lookups between accesses
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      red_current_out <= php_pkg::BYTE_ZERO;
      green_current_out <= php_pkg::BYTE_ZERO;
      blue_current_out <= php_pkg::BYTE_ZERO;
    end
    else if (host_selected)
    begin
      // pixel inputs ignored, outputs at black
      red_current_out <= php_pkg::BYTE_ZERO; // RL2 RL10
      green_current_out <= php_pkg::BYTE_ZERO; // RL10
      blue_current_out <= php_pkg::BYTE_ZERO; // RL10
    end
    else
    begin
      // storage free of host traffic, take a lookup
      red_current_out <= pix_word.red; // RL12
      green_current_out <= pix_word.green; // RL12
      blue_current_out <= pix_word.blue; // RL12
    end
  end

endmodule

// file: testbench/php_palette_port_assertions.sv
`timescale 1ns/1ns

// pin level relations of the palette host port
module php_palette_port_chk #(
  parameter int unsigned DEPTH = php_pkg::DEPTH
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic host_sel_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic cmd_sel_lo,
  input wire logic cmd_sel_hi,
  input wire logic [7:0] host_data_bus_in,
  input wire logic [7:0] host_data_bus_out,
  input wire logic host_data_bus_oe,
  input wire logic [7:0] pixel_index,
  input wire logic overlay_sel_bit0,
  input wire logic overlay_sel_bit1,
  input wire logic [7:0] red_current_out,
  input wire logic [7:0] green_current_out,
  input wire logic [7:0] blue_current_out
);
  logic rd_win; // select and read low, write high
  logic wr_win; // select and write low, read high
  logic [3:0] rd_gap_r; // cycles since a read window
  logic [3:0] rd_gap_nxt;
  logic [23:0] video; // three colour codes together
  assign rd_win = !host_sel_n && !host_rd_n && host_wr_n;
  assign wr_win = !host_sel_n && !host_wr_n && host_rd_n;
  assign video = {red_current_out, green_current_out, blue_current_out};
  assign rd_gap_nxt = rd_win ? 4'h0 :
    (rd_gap_r == 4'hf) ? rd_gap_r : rd_gap_r + 4'h1;
  // saturating gap counter
  always_ff @(posedge core_clk)
  begin
    if (srst)
      rd_gap_r <= 4'hf;
    else
      rd_gap_r <= rd_gap_nxt;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  a_oe_recent_read: assert property (host_data_bus_oe |-> rd_gap_r <= 4'h8)
    else $error("bus driven with no recent read window");
  a_rd_release: assert property (host_rd_n [*8] |-> !host_data_bus_oe)
    else $error("bus driven long after read strobe rose");
  a_sel_release: assert property (host_sel_n [*8] |-> !host_data_bus_oe)
    else $error("bus driven while not selected");
  a_wr_quiet: assert property (wr_win [*8] |-> !host_data_bus_oe)
    else $error("bus driven during a write");
  a_rd_drive: assert property (rd_win [*8] |-> host_data_bus_oe)
    else $error("bus not driven during a read");
  a_out_hold: assert property (host_data_bus_oe && $past(host_data_bus_oe)
    |-> $stable(host_data_bus_out))
    else $error("read byte changed while driven");
  a_black_sel: assert property (!host_sel_n [*8] |-> video == 24'h000000)
    else $error("video not black while selected");
  a_video_steady: assert property ((host_sel_n && $stable(pixel_index) &&
    $stable({overlay_sel_bit1, overlay_sel_bit0})) [*8]
    |-> $stable(video))
    else $error("video moved with steady pixel inputs");
endmodule

bind php_palette_port php_palette_port_chk #(.DEPTH(DEPTH)) u_chk (
  .core_clk(core_clk), .srst(srst), .host_sel_n(host_sel_n),
  .host_rd_n(host_rd_n), .host_wr_n(host_wr_n), .cmd_sel_lo(cmd_sel_lo),
  .cmd_sel_hi(cmd_sel_hi), .host_data_bus_in(host_data_bus_in),
  .host_data_bus_out(host_data_bus_out),
  .host_data_bus_oe(host_data_bus_oe), .pixel_index(pixel_index),
  .overlay_sel_bit0(overlay_sel_bit0), .overlay_sel_bit1(overlay_sel_bit1),
  .red_current_out(red_current_out), .green_current_out(green_current_out),
  .blue_current_out(blue_current_out));

// file: testbench/php_host_model.sv
`timescale 1ns/1ns

// behavioural host processor on the port pins
module php_host_model (
  input wire logic core_clk,
  input wire logic dev_oe,
  input wire logic [7:0] dev_out,
  output php_pkg::php_pins_t pins
);
  logic sel_n = 1'b1; // select, active low
  logic rd_n = 1'b1; // read strobe, active low
  logic wr_n = 1'b1; // write strobe, active low
  logic c_hi = 1'b0; // command high bit
  logic c_lo = 1'b0; // command low bit
  logic drv = 1'b0; // host drives the bus
  logic [7:0] wdat = 8'h00; // byte driven by host
  logic [7:0] last = 8'h00; // last bus level
  logic [7:0] bus_lvl; // resolved bus level
  // released bus shows the inverse of its last level
  assign bus_lvl = dev_oe ? dev_out : (drv ? wdat : ~last);
  assign pins = {sel_n, rd_n, wr_n, c_hi, c_lo, bus_lvl};
  // memory of the bus level
  always @(posedge core_clk)
    last <= bus_lvl;
  // one strobe cycle, 8 clocks low then 8 high
  task automatic xfer(input logic hi, input logic lo, input logic wr,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk);
    sel_n <= 1'b0;
    rd_n <= wr;
    wr_n <= !wr;
    c_hi <= hi;
    c_lo <= lo;
    wdat <= d;
    drv <= wr;
    repeat (8) @(posedge core_clk);
    q = bus_lvl;
    sel_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    // data held past the rising strobes
    repeat (8) @(posedge core_clk);
    drv <= 1'b0;
  endtask
endmodule

// file: testbench/test_palette_host_port.sv
`timescale 1ns/1ns

// self checking bench for the palette host port
module test_palette_host_port;
  logic core_clk = 1'b0; // core clock
  logic srst = 1'b1; // synchronous reset
  logic [7:0] pix = 8'h00; // pixel index
  logic [1:0] ovl = 2'h1; // overlay one at start, reset leaves it unchanged
  php_pkg::php_pins_t pins; // host pins
  logic [7:0] d_out; // device read byte
  logic d_oe; // device bus enable
  logic [7:0] red, grn, blu; // colour codes
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  always #25 core_clk = ~core_clk;
  php_host_model u_php_host_model (.core_clk(core_clk), .dev_oe(d_oe),
    .dev_out(d_out), .pins(pins));
  php_palette_port u_php_palette_port (.core_clk(core_clk), .srst(srst),
    .host_sel_n(pins.sel_n), .host_rd_n(pins.rd_n), .host_wr_n(pins.wr_n),
    .cmd_sel_lo(pins.cmd_lo), .cmd_sel_hi(pins.cmd_hi),
    .host_data_bus_in(pins.data), .host_data_bus_out(d_out),
    .host_data_bus_oe(d_oe), .pixel_index(pix),
    .overlay_sel_bit0(ovl[0]), .overlay_sel_bit1(ovl[1]),
    .red_current_out(red), .green_current_out(grn),
    .blue_current_out(blu));
  // verdict and end of run
  task automatic wrap_up;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      failures++;
      wrap_up();
    end
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic hi, input logic lo, input logic [7:0] d);
    logic [7:0] q;
    u_php_host_model.xfer(hi, lo, 1'b1, d, q);
  endtask
  task automatic rd(input logic hi, input logic lo, input logic [7:0] e);
    logic [7:0] q;
    u_php_host_model.xfer(hi, lo, 1'b0, 8'h00, q);
    check({16'h0000, q}, {16'h0000, e});
  endtask
  // red, green, blue bytes in turn
  task automatic wrcol(input logic hi, input logic [23:0] c);
    wr(hi, 1'b1, c[23:16]);
    wr(hi, 1'b1, c[15:8]);
    wr(hi, 1'b1, c[7:0]);
  endtask
  task automatic rdcol(input logic hi, input logic [23:0] c);
    rd(hi, 1'b1, c[23:16]);
    rd(hi, 1'b1, c[15:8]);
    rd(hi, 1'b1, c[7:0]);
  endtask
  // pointer load and repeated reads
  task automatic t_pointer;
    wr(1'b0, 1'b0, 8'ha5);
    rd(1'b0, 1'b0, 8'ha5);
    rd(1'b1, 1'b0, 8'ha5);
    wr(1'b1, 1'b0, 8'h5a);
    rd(1'b0, 1'b0, 8'h5a);
  endtask
  // palette words across the top location
  task automatic t_palette;
    wr(1'b0, 1'b0, 8'hfe);
    wrcol(1'b0, 24'h123456);
    wrcol(1'b0, 24'habcdef);
    rd(1'b0, 1'b0, 8'h00);
    wr(1'b0, 1'b0, 8'hfe);
    rdcol(1'b0, 24'h123456);
    rdcol(1'b0, 24'habcdef);
    rd(1'b0, 1'b0, 8'h00);
  endtask
  // phase cleared by pointer write, kept by pointer read
  task automatic t_phase;
    wr(1'b0, 1'b0, 8'h40);
    wr(1'b0, 1'b1, 8'h11);
    wr(1'b0, 1'b1, 8'h22);
    wr(1'b0, 1'b0, 8'h40);
    wr(1'b0, 1'b1, 8'h33);
    rd(1'b0, 1'b0, 8'h40);
    wr(1'b0, 1'b1, 8'h44);
    wr(1'b0, 1'b1, 8'h55);
    rd(1'b0, 1'b0, 8'h41);
    wr(1'b0, 1'b0, 8'h40);
    rdcol(1'b0, 24'h334455);
  endtask
  // overlay slots, ignored upper bits, reserved slot
  task automatic t_overlay;
    wr(1'b1, 1'b0, 8'hfd);
    wrcol(1'b1, 24'h10e0a5);
    wrcol(1'b1, 24'h5a3c7e);
    wrcol(1'b1, 24'hc3810f);
    rd(1'b0, 1'b0, 8'h00);
    wr(1'b1, 1'b0, 8'hfc);
    wrcol(1'b1, 24'hffffff);
    rd(1'b0, 1'b0, 8'hfd);
    wr(1'b0, 1'b0, 8'h04);
    rdcol(1'b1, 24'h000000);
    rdcol(1'b1, 24'h10e0a5);
    rdcol(1'b1, 24'h5a3c7e);
    wr(1'b0, 1'b0, 8'hfe);
    rdcol(1'b0, 24'h123456);
  endtask
  task automatic vid(input logic [7:0] p, input logic [1:0] o);
    @(posedge core_clk);
    pix <= p;
    ovl <= o;
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  // pixel lookups, and black while selected
  task automatic t_video;
    vid(8'hfe, 2'h0);
    check({red, grn, blu}, 24'h123456);
    vid(8'h00, 2'h2);
    check({red, grn, blu}, 24'h5a3c7e);
    vid(8'h00, 2'h3);
    check({red, grn, blu}, 24'hc3810f);
    vid(8'hff, 2'h1);
    fork
      rd(1'b0, 1'b0, 8'hff);
    join_none
    repeat (8) @(posedge core_clk);
    #1;
    check({red, grn, blu}, 24'h000000);
    wait fork;
    vid(8'hff, 2'h1);
    check({red, grn, blu}, 24'h10e0a5);
  endtask
  // main sequence
  initial
  begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    t_pointer();
    t_palette();
    t_phase();
    t_overlay();
    t_video();
    wrap_up();
  end
endmodule
